// *** include/sdram_defs.svh ***
// shared constants of the sdram controller and its memory end
`ifndef SDRAM_DEFS_SVH
`define SDRAM_DEFS_SVH
// ----------------------------------------
// clock and cycle conversion
// ----------------------------------------
`define CLK_PS 40000
`define CLK_MHZ 25
`define CL1_MAX_MHZ 40
`define CYC_UP(ps) (((ps) + `CLK_PS - 1) / `CLK_PS)
`define CYC_DN(ps) ((ps) / `CLK_PS)
// ----------------------------------------
// array timing, picoseconds, per speed grade
// ----------------------------------------
`define T_RRD_F_PS 15000
`define T_RRD_S_PS 18000
`define T_RC_F_PS 72500
`define T_RC_M_PS 74000
`define T_RC_S_PS 77000
`define T_RDL_PS 15000
`define T_RP_PS 22500
`define T_RCD_PS 22500
`define T_ARFC_PS 80000
`define T_SRFX_PS 120000
`define T_POWERUP_PS 200000000
`define REF_WIN_NS 64000000
`define REF_COUNT 8192
`define MRS_GAP 2
`define INIT_REFS 2'h2
// ----------------------------------------
// mode word fields on the address pins
// ----------------------------------------
`define MR_BL_LSB 0
`define MR_BT 3
`define MR_LAT_LSB 4
`define MR_WS 9
`define AP_BIT 10
`define COL_W 10
`define BL_FULL 3'h7
`define MEM_RST_LAT 3'h2
// ----------------------------------------
// controller register map and fields
// ----------------------------------------
`define RA_CFG 8'h00
`define RA_ADDR 8'h04
`define RA_WDATA 8'h08
`define RA_CMD 8'h0c
`define RA_RDATA 8'h10
`define RA_STATUS 8'h14
`define CF_LAT_LSB 0
`define CF_BT 2
`define CF_BL_LSB 3
`define CF_WS 6
`define CF_BEN_LSB 7
`define CFG_RST 9'h182
`define AD_ROW_LSB 10
`define AD_BANK_LSB 23
`define OP_NONE 3'h0
`define OP_RD 3'h1
`define OP_WR 3'h2
`define OP_SELF 3'h3
`define OP_EXIT 3'h4
`endif

// *** include/sdram_pkg.sv ***
// types shared by the sdram controller and the memory end
package sdram_pkg;
  typedef enum logic [2:0] {CMD_NOP, CMD_MODE, CMD_REF, CMD_ACT, CMD_RD, CMD_WR, CMD_BST,
    CMD_PRE} cmd_t;
  typedef enum logic [2:0] {S_POWER, S_IDLE, S_POST, S_RDWAIT, S_SELF} ctl_st_t;

  // {ras_n, cas_n, we_n} for each command
  function automatic logic [2:0] cmd_pins(cmd_t c);
    logic [2:0] p;
    p = 3'h7;
    unique case (c)
      CMD_NOP: p = 3'h7;
      CMD_MODE: p = 3'h0;
      CMD_REF: p = 3'h1;
      CMD_ACT: p = 3'h3;
      CMD_RD: p = 3'h5;
      CMD_WR: p = 3'h4;
      CMD_BST: p = 3'h6;
      CMD_PRE: p = 3'h2;
    endcase
    return p;
  endfunction

  function automatic cmd_t cmd_decode(logic [2:0] p);
    cmd_t c;
    c = CMD_NOP;
    unique case (p)
      3'h7: c = CMD_NOP;
      3'h0: c = CMD_MODE;
      3'h1: c = CMD_REF;
      3'h3: c = CMD_ACT;
      3'h5: c = CMD_RD;
      3'h4: c = CMD_WR;
      3'h6: c = CMD_BST;
      3'h2: c = CMD_PRE;
    endcase
    return c;
  endfunction
endpackage

// *** include/sdram_if.sv ***
// pin bundle between the sdram controller and the memory end
`timescale 1ns/1ps
interface sdram_if;
  logic cke;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [1:0] bank_index;
  logic [12:0] a;
  logic [1:0] dqm;
  logic [15:0] dq_c;
  logic dq_c_oe_n;
  logic [15:0] dq_m;
  logic [1:0] dq_m_oe_n;
  logic [15:0] dq;

  // resolved data wire, per byte; nobody driving reads as zero
  assign dq[7:0] = !dq_m_oe_n[0] ? dq_m[7:0] : (!dq_c_oe_n ? dq_c[7:0] : 8'h00);
  assign dq[15:8] = !dq_m_oe_n[1] ? dq_m[15:8] : (!dq_c_oe_n ? dq_c[15:8] : 8'h00);

  modport ctrl (output cke, cs_n, ras_n, cas_n, we_n, bank_index, a, dqm, dq_c, dq_c_oe_n,
    input dq);
  modport mem (input cke, cs_n, ras_n, cas_n, we_n, bank_index, a, dqm, dq,
    output dq_m, dq_m_oe_n);
endinterface

// *** hdl/sdram_mem.sv ***
// memory end: four-bank 16-bit synchronous dram command and burst logic
`timescale 1ns/1ps
`include "sdram_defs.svh"
module sdram_mem #(
  parameter int COL_BITS = `COL_W
) (
  input wire logic REF_CLK,
  input wire logic ARST_N,
  sdram_if.mem MEM,
  output logic [3:0] BANK_OPEN,
  output logic BURST_BUSY
);
  typedef struct packed {
    logic cke_q;
    logic [2:0] lat;
    logic bt;
    logic [2:0] bl;
    logic ws;
    logic [3:0] open;
    logic rd;
    logic wr;
    logic ap;
    logic [1:0] bk;
    logic [COL_BITS-1:0] c0;
    logic [COL_BITS-1:0] cnt;
    logic [2:0] pv;
    logic [2:0][15:0] pd;
    logic [1:0][1:0] mk;
  } mem_t;

  localparam mem_t RST = '{lat: `MEM_RST_LAT, default: '0};

  // rows alias onto one page per bank to keep the array small
  logic [1:0][7:0] mem [0:(4 << COL_BITS)-1];
  mem_t r;
  mem_t n;
  logic [1:0] wen;
  logic [COL_BITS+1:0] idx;

  // ----------------------------------------
  // burst helpers
  // ----------------------------------------
  // index of the last word of a burst
  function automatic logic [COL_BITS-1:0] last_ix(logic [2:0] bl, logic single);
    logic [COL_BITS-1:0] m;
    m = '0;
    if (!single) begin
      unique case (bl)
        3'h1: m = COL_BITS'(1);
        3'h2: m = COL_BITS'(3);
        3'h3: m = COL_BITS'(7);
        `BL_FULL: m = '1;
        default: m = '0;
      endcase
    end
    return m;
  endfunction

  // column of word k; wraps inside the burst-sized block
  function automatic logic [COL_BITS-1:0] bcol(logic [COL_BITS-1:0] c0,
      logic [COL_BITS-1:0] k, logic [COL_BITS-1:0] m, logic ilv);
    logic [COL_BITS-1:0] s;
    s = ilv ? (c0 ^ k) : (c0 + k);
    return (c0 & ~m) | (s & m);
  endfunction

  // ----------------------------------------
  // command decode and burst engine
  // ----------------------------------------
  always_comb begin
    sdram_pkg::cmd_t c;
    logic [COL_BITS-1:0] m;
    logic [1:0] li;
    c = sdram_pkg::CMD_NOP;
    m = '0;
    li = '0;
    n = r;
    wen = '0;
    idx = '0;
    n.cke_q = MEM.cke;
    n.pv = {1'b0, r.pv[2:1]};
    n.pd = {16'h0000, r.pd[2:1]};
    n.mk = {MEM.dqm, r.mk[1]};
    n.cnt = r.cnt + 1'b1;
    // commands count only while clock enable was high at the previous edge
    if (r.cke_q && !MEM.cs_n) begin
      c = sdram_pkg::cmd_decode({MEM.ras_n, MEM.cas_n, MEM.we_n}); // R01
    end
    if (c == sdram_pkg::CMD_MODE) begin
      n.lat = MEM.a[`MR_LAT_LSB +: 3]; // R02
      n.bt = MEM.a[`MR_BT]; // R04
      n.bl = MEM.a[`MR_BL_LSB +: 3]; // R03
      n.ws = MEM.a[`MR_WS]; // R05
    end else if (c == sdram_pkg::CMD_ACT) begin
      n.open[MEM.bank_index] = 1'b1; // R07
    end else if (c == sdram_pkg::CMD_RD || c == sdram_pkg::CMD_WR) begin
      // a new column command cuts any burst short, every cycle
      n.rd = (c == sdram_pkg::CMD_RD); // R17
      n.wr = (c == sdram_pkg::CMD_WR);
      n.bk = MEM.bank_index;
      n.c0 = MEM.a[COL_BITS-1:0];
      n.cnt = '0;
      n.ap = MEM.a[`AP_BIT];
    end else if (c == sdram_pkg::CMD_BST) begin
      n.rd = 1'b0; // R18
      n.wr = 1'b0;
    end else if (c == sdram_pkg::CMD_PRE) begin
      if (MEM.a[`AP_BIT]) begin
        n.open = '0;
      end else begin
        n.open[MEM.bank_index] = 1'b0;
      end
      if (MEM.a[`AP_BIT] || MEM.bank_index == r.bk) begin
        n.rd = 1'b0; // R18
        n.wr = 1'b0;
      end
    end
    // one word per cycle; words already queued still leave the pipe
    if (n.rd || n.wr) begin
      m = last_ix(n.bl, n.wr && n.ws); // R05
      idx = {n.bk, bcol(n.c0, n.cnt, last_ix(n.bl, 1'b0),
        n.bt && n.bl != `BL_FULL)}; // R04
      if (n.rd) begin
        li = (n.lat == 3'h0) ? 2'h0 : 2'(n.lat - 3'h1);
        n.pv[li] = 1'b1; // R02
        n.pd[li] = mem[idx];
      end else begin
        wen = ~MEM.dqm; // R20
      end
      if (n.cnt == m) begin
        n.rd = 1'b0; // R03
        n.wr = 1'b0;
        if (n.ap) begin
          n.open[n.bk] = 1'b0;
        end
      end
    end
  end

  // all state registered on the rising edge
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      r <= RST;
    end else begin
      r <= n; // R01
    end
  end

  // ----------------------------------------
  // array write, both byte lanes in one process
  // ----------------------------------------
  // one process owns the whole array, so the two lanes share one writer
  always_ff @(posedge REF_CLK) begin
    for (int i = 0; i < 2; i++) begin
      if (wen[i]) begin
        mem[idx][i] <= MEM.dq[8*i +: 8]; // R20
      end
    end
  end

  // read mask acts two edges after it was sampled
  assign MEM.dq_m = r.pd[0];
  assign MEM.dq_m_oe_n[0] = ~(r.pv[0] & ~r.mk[0][0]); // R20
  assign MEM.dq_m_oe_n[1] = ~(r.pv[0] & ~r.mk[0][1]);
  assign BANK_OPEN = r.open;
  assign BURST_BUSY = r.rd | r.wr;
endmodule

// *** hdl/sdram_ctrl.sv ***
// controller end: register port in, sdram command pins out
`timescale 1ns/1ps
`include "sdram_defs.svh"
// Contract
// R01: all pins sampled on rising clock edge
// R02: read latency one, two or three
// R03: burst length 1, 2, 4, 8, page
// R04: sequential or interleaved burst column order
// R05: optional single-word writes with read bursts
// R06: 8K refreshes every 64 ms
// R07: four banks of 16-bit words
// R08: latency one only at 40 MHz or less
// R09: activate to activate, any bank, spaced
// R10: same-bank activations spaced by row cycle
// R11: write recovery before precharging the bank
// R12: write recovery plus precharge before activate
// R13: one clock after write data to column
// R14: one clock after write data to stop
// R15: refresh cycle time before next array command
// R16: self refresh exit wait before activate
// R17: column command accepted every clock
// R18: stopped reads still deliver latency-minus-one words
// R19: nanoseconds to cycles, rounded up
// R20: mask blocks writes now, reads two later
// R21: mode set with banks idle, two-clock gap
// R22: bank state and counters tracked per bank
module sdram_ctrl #(
  parameter int GRADE = 0,
  parameter int POWERUP_CYC = `CYC_UP(`T_POWERUP_PS)
) (
  input wire logic REF_CLK,
  input wire logic ARST_N,
  input wire logic [7:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  sdram_if.ctrl MEM
);
  // ----------------------------------------
  // timing in cycles
  // ----------------------------------------
  // least spacings round up, the refresh interval rounds down
  localparam int RRD_C = `CYC_UP(GRADE == 0 ? `T_RRD_F_PS : `T_RRD_S_PS); // R19
  localparam int RC_C = `CYC_UP(GRADE == 0 ? `T_RC_F_PS :
    (GRADE == 1 ? `T_RC_M_PS : `T_RC_S_PS)); // R19
  localparam int RDL_C = `CYC_UP(`T_RDL_PS);
  localparam int RP_C = `CYC_UP(`T_RP_PS);
  localparam int RCD_C = `CYC_UP(`T_RCD_PS);
  localparam int ARFC_C = `CYC_UP(`T_ARFC_PS);
  localparam int SRFX_C = `CYC_UP(`T_SRFX_PS);
  localparam int REF_C = `CYC_DN(`REF_WIN_NS / `REF_COUNT * 1000);
  localparam bit CL1_OK = (`CLK_MHZ <= `CL1_MAX_MHZ);

  typedef struct packed {
    sdram_pkg::ctl_st_t st;
    logic [15:0] pw;
    logic [7:0] wt;
    logic [3:0] rrd;
    logic [3:0][3:0] rc;
    logic [3:0][3:0] wr;
    logic [3:0] open;
    logic [3:0][12:0] row;
    logic [11:0] rfc;
    logic due;
    logic [1:0] refs;
    logic dirty;
    logic rd_op;
    logic bst;
    logic [8:0] cfg;
    logic [24:0] addr;
    logic [15:0] wdata;
    logic [2:0] op;
    logic [15:0] rdata;
    logic [31:0] rdout;
    logic cke;
    logic cs_n;
    logic [2:0] cmd;
    logic [1:0] ba;
    logic [12:0] a;
    logic [1:0] dqm;
    logic [15:0] dq;
    logic dq_oe_n;
  } ctl_t;

  localparam ctl_t RST = '{st: sdram_pkg::S_POWER, pw: 16'(POWERUP_CYC - 1),
    refs: `INIT_REFS, dirty: 1'b1, cfg: `CFG_RST, cke: 1'b1, cs_n: 1'b1,
    cmd: 3'h7, dq_oe_n: 1'b1, default: '0};

  ctl_t r;
  ctl_t n;

  // put a command on the pins for the next cycle
  function automatic ctl_t put(ctl_t s, sdram_pkg::cmd_t c);
    ctl_t t;
    t = s;
    t.cs_n = 1'b0;
    t.cmd = sdram_pkg::cmd_pins(c);
    return t;
  endfunction

  // latency actually programmed; one only when the clock is slow enough
  function automatic logic [2:0] eff_lat(logic [1:0] req);
    logic [2:0] l;
    l = {1'b0, req};
    if (req == 2'h0 || (req == 2'h1 && !CL1_OK)) begin
      l = 3'h2; // R08
    end
    return l;
  endfunction

  // ----------------------------------------
  // sequencer, counters and register port
  // ----------------------------------------
  always_comb begin
    logic [1:0] b;
    logic [12:0] rw;
    logic wr_idle;
    logic tick;
    logic [2:0] lat;
    b = r.addr[`AD_BANK_LSB +: 2];
    rw = r.addr[`AD_ROW_LSB +: 13];
    lat = eff_lat(r.cfg[`CF_LAT_LSB +: 2]);
    wr_idle = 1'b1;
    tick = 1'b0;
    n = r;
    n.cs_n = 1'b1;
    n.cmd = sdram_pkg::cmd_pins(sdram_pkg::CMD_NOP);
    n.dqm = 2'h0;
    n.dq_oe_n = 1'b1;
    if (r.wt != 8'h00) begin
      n.wt = r.wt - 8'h01;
    end
    if (r.rrd != 4'h0) begin
      n.rrd = r.rrd - 4'h1;
    end
    // every bank counts down on its own
    for (int i = 0; i < 4; i++) begin
      if (r.rc[i] != 4'h0) begin
        n.rc[i] = r.rc[i] - 4'h1; // R22
      end
      if (r.wr[i] != 4'h0) begin
        n.wr[i] = r.wr[i] - 4'h1; // R22
        wr_idle = 1'b0;
      end
    end
    // refresh interval timer stops while the memory refreshes itself
    if (r.st != sdram_pkg::S_SELF && r.st != sdram_pkg::S_POWER) begin
      if (r.rfc == 12'(REF_C - 1)) begin
        n.rfc = 12'h000;
        tick = 1'b1; // R06
      end else begin
        n.rfc = r.rfc + 12'h001;
      end
    end
    unique case (r.st)
      sdram_pkg::S_POWER: begin
        if (r.pw != 16'h0000) begin
          n.pw = r.pw - 16'h0001;
        end else begin
          n = put(n, sdram_pkg::CMD_PRE);
          n.a[`AP_BIT] = 1'b1;
          n.wt = 8'(RP_C - 1);
          n.st = sdram_pkg::S_IDLE;
        end
      end
      sdram_pkg::S_IDLE: begin
        if (r.wt != 8'h00) begin
          // spacing after precharge, activate, refresh, mode set or self refresh exit
          n.st = sdram_pkg::S_IDLE; // R15 R16 R21
        end else if ((r.due || r.refs != 2'h0 || r.dirty || r.op == `OP_SELF)
            && r.open != 4'h0) begin
          if (wr_idle) begin
            n = put(n, sdram_pkg::CMD_PRE); // R11
            n.a[`AP_BIT] = 1'b1;
            n.open = 4'h0;
            n.wt = 8'(RP_C - 1);
          end
        end else if (r.due || r.refs != 2'h0) begin
          n = put(n, sdram_pkg::CMD_REF); // R06
          n.wt = 8'(ARFC_C - 1); // R15
          if (r.refs != 2'h0) begin
            n.refs = r.refs - 2'h1;
          end else begin
            n.due = 1'b0;
          end
        end else if (r.dirty) begin
          // only reached with every bank closed
          n = put(n, sdram_pkg::CMD_MODE); // R21
          n.ba = 2'h0;
          n.a = 13'h0000;
          n.a[`MR_BL_LSB +: 3] = r.cfg[`CF_BL_LSB +: 3]; // R03
          n.a[`MR_BT] = r.cfg[`CF_BT]; // R04
          n.a[`MR_LAT_LSB +: 3] = lat; // R02
          n.a[`MR_WS] = r.cfg[`CF_WS]; // R05
          n.wt = 8'(`MRS_GAP - 1); // R21
          n.dirty = 1'b0;
        end else if (r.op == `OP_SELF) begin
          n = put(n, sdram_pkg::CMD_REF);
          n.cke = 1'b0;
          n.op = `OP_NONE;
          n.st = sdram_pkg::S_SELF;
        end else if (r.op == `OP_RD || r.op == `OP_WR) begin
          if (r.open[b] && r.row[b] == rw) begin
            n = put(n, r.op == `OP_RD ? sdram_pkg::CMD_RD : sdram_pkg::CMD_WR);
            n.ba = b;
            n.a = 13'h0000;
            n.a[`COL_W-1:0] = r.addr[`COL_W-1:0];
            n.rd_op = (r.op == `OP_RD);
            n.bst = (r.cfg[`CF_BL_LSB +: 3] != 3'h0)
              && !(r.op == `OP_WR && r.cfg[`CF_WS]);
            n.wt = {5'h00, lat};
            n.st = sdram_pkg::S_POST;
            if (r.op == `OP_WR) begin
              n.dq = r.wdata;
              n.dq_oe_n = 1'b0;
              n.dqm = ~r.cfg[`CF_BEN_LSB +: 2]; // R20
              n.wr[b] = 4'(RDL_C); // R11 R12
              n.op = `OP_NONE;
            end
          end else if (r.open[b]) begin
            if (r.wr[b] == 4'h0) begin
              n = put(n, sdram_pkg::CMD_PRE); // R11 R22
              n.ba = b;
              n.open[b] = 1'b0;
              n.wt = 8'(RP_C - 1); // R12
            end
          end else if (r.rc[b] == 4'h0 && r.rrd == 4'h0) begin
            n = put(n, sdram_pkg::CMD_ACT); // R09 R10
            n.ba = b;
            n.a = rw;
            n.open[b] = 1'b1; // R07 R22
            n.row[b] = rw;
            n.rc[b] = 4'(RC_C - 1); // R10
            n.rrd = 4'(RRD_C - 1); // R09
            n.wt = 8'(RCD_C - 1);
          end
        end
      end
      sdram_pkg::S_POST: begin
        // the stop lands a clock after the write word; mask any stray word
        if (r.bst) begin
          n = put(n, sdram_pkg::CMD_BST); // R13 R14
          n.dqm = (r.rd_op && lat == 3'h3) ? 2'h0 : 2'h3; // R20: at latency three it hits word 0
        end
        n.st = r.rd_op ? sdram_pkg::S_RDWAIT : sdram_pkg::S_IDLE;
        if (!r.rd_op) begin
          n.wt = 8'h00;
        end
      end
      sdram_pkg::S_RDWAIT: begin
        // later words of a stopped burst are ignored here
        if (r.wt == 8'h00) begin
          n.rdata = MEM.dq; // R18
          n.op = `OP_NONE;
          n.st = sdram_pkg::S_IDLE;
        end
      end
      sdram_pkg::S_SELF: begin
        if (r.op == `OP_EXIT) begin
          n.cke = 1'b1;
          n.wt = 8'(SRFX_C - 1); // R16
          n.rfc = 12'h000;
          n.op = `OP_NONE;
          n.st = sdram_pkg::S_IDLE;
        end
      end
    endcase
    // a tick arriving as the flag is cleared is kept
    if (tick) begin
      n.due = 1'b1;
    end
    if (REG_WR) begin
      unique case (REG_ADDR)
        `RA_CFG: begin
          n.cfg = REG_WDATA[8:0];
          n.dirty = 1'b1;
        end
        `RA_ADDR: n.addr = REG_WDATA[24:0];
        `RA_WDATA: n.wdata = REG_WDATA[15:0];
        `RA_CMD: begin
          if (r.st == sdram_pkg::S_SELF) begin
            if (r.op == `OP_NONE && REG_WDATA[2:0] == `OP_EXIT) begin
              n.op = `OP_EXIT;
            end
          end else if (r.op == `OP_NONE && REG_WDATA[2:0] != `OP_EXIT) begin
            n.op = REG_WDATA[2:0];
          end
        end
        default: n.op = n.op;
      endcase
    end
    n.rdout = 32'h0000_0000;
    if (REG_RD) begin
      unique case (REG_ADDR)
        `RA_CFG: n.rdout = {23'h000000, r.cfg};
        `RA_ADDR: n.rdout = {7'h00, r.addr};
        `RA_WDATA: n.rdout = {16'h0000, r.wdata};
        `RA_CMD: n.rdout = {29'h00000000, r.op};
        `RA_RDATA: n.rdout = {16'h0000, r.rdata};
        `RA_STATUS: n.rdout = {24'h000000, r.open, 1'b0, r.st == sdram_pkg::S_SELF,
          r.st != sdram_pkg::S_POWER && !r.dirty && r.refs == 2'h0, r.op != `OP_NONE};
        default: n.rdout = 32'h0000_0000;
      endcase
    end
  end

  // pins change only right after a rising edge
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      r <= RST;
    end else begin
      r <= n; // R01
    end
  end

  assign REG_RDATA = r.rdout;
  assign MEM.cke = r.cke;
  assign MEM.cs_n = r.cs_n;
  assign MEM.ras_n = r.cmd[2];
  assign MEM.cas_n = r.cmd[1];
  assign MEM.we_n = r.cmd[0];
  assign MEM.bank_index = r.ba;
  assign MEM.a = r.a;
  assign MEM.dqm = r.dqm;
  assign MEM.dq_c = r.dq;
  assign MEM.dq_c_oe_n = r.dq_oe_n;
endmodule

// *** testbench/sdram_link_properties.sv ***
// link checker: command spacing and read data timing on the sdram pins
`timescale 1ns/1ps
module sdram_link_checker (
  input wire logic REF_CLK,
  input wire logic ARST_N,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [1:0] bank_index,
  input wire logic [12:0] a,
  input wire logic [1:0] dqm,
  input wire logic dq_c_oe_n,
  input wire logic [1:0] dq_m_oe_n
);
  typedef struct packed {
    logic [2:0] lat;
    logic [2:0] bl;
  } mode_t;
  mode_t st_r;
  mode_t st_nxt;
  logic [2:0] pins;
  logic cmd;
  logic act;
  logic rd;
  logic wr;
  logic bst;
  logic aref;
  logic mode;
  logic word;
  logic idle;
  // ----------------------------------------
  // command decode
  // ----------------------------------------
  assign pins = {ras_n, cas_n, we_n};
  assign cmd = !cs_n && pins != 3'h7;
  assign act = !cs_n && pins == 3'h3;
  assign rd = !cs_n && pins == 3'h5;
  assign wr = !cs_n && pins == 3'h4;
  assign bst = !cs_n && pins == 3'h6;
  assign aref = !cs_n && pins == 3'h1 && cke;  // low cke here means self refresh entry
  assign mode = !cs_n && pins == 3'h0;
  assign word = dq_m_oe_n == 2'h0;
  assign idle = dq_m_oe_n == 2'h3;
  // shadow of the mode word; reserved latency code acts as one
  always_comb begin
    st_nxt = st_r;
    if (mode) begin
      st_nxt.lat = (a[6:4] == 3'h0) ? 3'h1 : a[6:4];
      st_nxt.bl = a[2:0];
    end
  end
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      st_r <= {3'h2, 3'h0};
    end else begin
      st_r <= st_nxt;
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!ARST_N);
  // read of a multi-word burst cut by a stop on the next edge
  sequence s_stop(int l);
    rd && st_r.bl != 3'h0 && st_r.lat == l ##1 bst;
  endsequence
  a_same_bank_act: assert property (act |=> !(act && bank_index == $past(bank_index)))
    else $error("same bank activated on consecutive edges");
  a_refresh_gap: assert property (aref |=> !(act || rd || wr || aref || mode))
    else $error("array command too soon after auto refresh");
  a_exit_gap: assert property ($rose(cke) |-> !act [*3])
    else $error("activate too soon after self refresh exit");
  a_mode_gap: assert property (mode |=> !cmd)
    else $error("command too soon after mode programming");
  a_read_mask: assert property ((~dq_m_oe_n & $past(dqm, 2)) == 2'h0)
    else $error("masked read byte still driven");
  a_stop_lat_one: assert property (s_stop(1) |-> word ##1 idle)
    else $error("wrong word count after stop at latency one");
  a_stop_lat_two: assert property (s_stop(2) |-> idle ##1 word ##1 idle)
    else $error("wrong word count after stop at latency two");
  // a stop one edge after the read leaves only word 0 in the pipe
  a_stop_lat_three: assert property (s_stop(3) |-> idle ##1 idle ##1 word ##1 idle)
    else $error("wrong word count after stop at latency three");
  a_write_drive: assert property (wr |-> !dq_c_oe_n)
    else $error("write issued without data driven");
endmodule

// *** testbench/testbench.sv ***
// self-checking bench: controller and memory joined over the pin bundle
`timescale 1ns/1ps
`include "sdram_defs.svh"
module testbench;
  localparam int LIMIT = 20000;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic chk = 1'b0;
  logic chk_d = 1'b0;
  logic [31:0] exp_q[$];
  string name_q[$];
  int num_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic [15:0] d1;
  logic [15:0] d2;
  logic [8:0] cfg;
  logic [3:0] mem_open;
  logic mem_busy;
  logic [2:0] bl_codes[5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
  sdram_if bus();
  sdram_ctrl #(.POWERUP_CYC(10)) i_sdram_ctrl (.REF_CLK(ref_clk), .ARST_N(arst_n),
    .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_RDATA(reg_rdata), .MEM(bus));
  sdram_mem i_sdram_mem (.REF_CLK(ref_clk), .ARST_N(arst_n), .MEM(bus), .BANK_OPEN(mem_open),
    .BURST_BUSY(mem_busy));
  sdram_link_checker i_sdram_link_checker (.REF_CLK(ref_clk), .ARST_N(arst_n),
    .cke(bus.cke), .cs_n(bus.cs_n), .ras_n(bus.ras_n), .cas_n(bus.cas_n), .we_n(bus.we_n),
    .bank_index(bus.bank_index), .a(bus.a), .dqm(bus.dqm), .dq_c_oe_n(bus.dq_c_oe_n),
    .dq_m_oe_n(bus.dq_m_oe_n));
  // ----------------------------------------
  // clock, timeout, result monitor
  // ----------------------------------------
  always #20 ref_clk = ~ref_clk;
  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] ex, input logic [31:0] got);
    cmp_count++;
    if (got !== ex) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, ex, got);
    end
  endtask
  // a hang still reaches the verdict, counted as a mismatch
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      num_errors++;
      close_out();
    end
  end
  // read data stand one cycle only, so the oldest note is taken right then
  always @(posedge ref_clk) begin
    chk_d <= chk;
    if (chk_d) begin
      check(name_q.pop_front(), exp_q.pop_front(), reg_rdata);
    end
  end
  // ----------------------------------------
  // register port tasks
  // ----------------------------------------
  task automatic reg_write(input logic [7:0] ad, input logic [31:0] dt);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= dt;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd_cycle(input logic [7:0] ad, input logic c);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= ad;
    chk <= c;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    chk <= 1'b0;
  endtask
  task automatic expect_read(input string nm, input logic [7:0] ad, input logic [31:0] ex);
    name_q.push_back(nm);
    exp_q.push_back(ex);
    rd_cycle(ad, 1'b1);
  endtask
  // polls status under a bound; the final value is compared
  task automatic wait_status(input int b, input logic val);
    int n = 0;
    logic [31:0] v = 32'h0;
    do begin
      rd_cycle(`RA_STATUS, 1'b0);
      #1 v = reg_rdata;
      n++;
    end while (v[b] !== val && n < 200);
    check("status bit", {31'h0, val}, {31'h0, v[b]});
  endtask
  task automatic do_op(input logic [2:0] op);
    reg_write(`RA_CMD, {29'h0, op});
    wait_status(0, 1'b0);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(69));
    repeat (5) @(posedge ref_clk);
    arst_n <= 1'b1;
    expect_read("cfg reset", `RA_CFG, 32'h182);
    expect_read("unmapped", 8'h20, 32'h0);
    wait_status(1, 1'b1);
    // every latency with every burst length; order and write mode drawn at random
    for (int lat = 0; lat <= 3; lat++) begin
      for (int k = 0; k < 5; k++) begin
        cfg = {2'h3, 1'($urandom), bl_codes[k], 1'($urandom), 2'(lat)};
        reg_write(`RA_CFG, {23'h0, cfg});
        expect_read("cfg", `RA_CFG, {23'h0, cfg});
        wait_status(0, 1'b0);
        d1 = 16'($urandom);
        reg_write(`RA_ADDR, {7'h0, 2'(k), 23'($urandom)});
        reg_write(`RA_WDATA, {16'h0, d1});
        do_op(`OP_WR);
        do_op(`OP_RD);
        expect_read("read word", `RA_RDATA, {16'h0, d1});
        check("burst busy", 32'h0, {31'h0, mem_busy});
      end
    end
    // high byte masked on the write keeps its old contents
    d1 = 16'($urandom);
    d2 = 16'($urandom);
    reg_write(`RA_ADDR, 32'h0180_0005);
    reg_write(`RA_WDATA, {16'h0, d1});
    do_op(`OP_WR);
    reg_write(`RA_CFG, 32'h0000_00c2);
    wait_status(0, 1'b0);
    reg_write(`RA_WDATA, {16'h0, d2});
    do_op(`OP_WR);
    do_op(`OP_RD);
    expect_read("masked write", `RA_RDATA, {16'h0, d1[15:8], d2[7:0]});
    // self refresh round trip keeps data
    do_op(`OP_SELF);
    wait_status(2, 1'b1);
    check("open in self refresh", 32'h0, {28'h0, mem_open});
    repeat (50) @(posedge ref_clk);
    reg_write(`RA_CMD, {29'h0, `OP_EXIT});
    wait_status(2, 1'b0);
    wait_status(0, 1'b0);
    do_op(`OP_RD);
    expect_read("after self refresh", `RA_RDATA, {16'h0, d1[15:8], d2[7:0]});
    // idle across two refresh periods, contents must survive
    repeat (400) @(posedge ref_clk);
    do_op(`OP_RD);
    expect_read("after refresh", `RA_RDATA, {16'h0, d1[15:8], d2[7:0]});
    repeat (4) @(posedge ref_clk);
    close_out();
  end
endmodule
